// [sawd_top.sv]
// SAR converter control with start sources, justification and window detect
// What this block does
// - Ground negative input means single-ended; any other selection means differential.
// - Negative select codes pick port pins, reference or ground; some are reserved.
// - Upper three negative-select bits read zero and ignore writes.
// - Conversion clock is system clock divided by divider field plus one; resets ones.
// - Justify bit zero stores right-justified results, one stores left-justified.
// - Right-justified high byte holds two top bits, sign-extended from bit one.
// - Left-justified high byte holds eight top bits; low byte bits 5-0 zero.
// - Enable zero shuts the converter down; one makes it ready.
// - Normal track mode tracks continuously except during conversion.
// - Done flag sets when busy falls at conversion end; stays until cleared.
// - Busy reads one while converting; writing one starts only with software source.
// - Start source field selects software, timer 0/2/1/3 overflow or pin edge.
// - Low-power mode with software or timer trigger tracks three clocks, then converts.
// - Low-power mode with pin source tracks while low, converts on rising edge.
// - Every result is compared with limits; match sets the window flag.
// - Window flag stays set until software clears it.
// - Inside window needs result above greater-than and below less-than limit.
// - Outside window matches below lower bound or above upper bound.
// - Single-ended results compared unsigned, differential with signed comparison.
// - In differential mode an all-ones limit compares as minus one.
// - Each conversion lasts at least ten conversion clocks.
// - Timers 2 and 3 use low overflow in split mode, high otherwise.
`timescale 1ns/1ns
`include "sawd_params.svh"

module sawd_top import sawd_pkg::*; (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Register bus
    input  wire sawd_apb_req_t apb_req,
    output sawd_apb_rsp_t      apb_rsp,
    // Start sources
    input  wire sawd_timer_t   timers,
    input  wire logic          ext_convert_start,
    // Converter array
    input  wire logic [9:0]    sar_result,
    output sawd_ana_t          ana
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic at_reg(input logic [11:0] addr, input logic [7:0] idx);
        at_reg = (addr == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic mapped(input logic [11:0] addr);
        mapped = at_reg(addr, `SAWD_IDX_NEG) | at_reg(addr, `SAWD_IDX_CFG)
               | at_reg(addr, `SAWD_IDX_RESL) | at_reg(addr, `SAWD_IDX_RESH)
               | at_reg(addr, `SAWD_IDX_LTL) | at_reg(addr, `SAWD_IDX_LTH)
               | at_reg(addr, `SAWD_IDX_GTL) | at_reg(addr, `SAWD_IDX_GTH)
               | at_reg(addr, `SAWD_IDX_CTL);
    endfunction

    // Result word as seen in the two byte registers
    function automatic logic [15:0] fmt(input logic [9:0] raw, input logic lj);
        if (lj) begin
            fmt = {raw, 6'h00};
        end else begin
            fmt = {{6{raw[9]}}, raw};
        end
    endfunction

    // Flipping the top bit turns a signed compare into an unsigned one
    function automatic logic win_hit(input logic [15:0] v, input logic [15:0] gt,
                                     input logic [15:0] lt, input logic diff);
        logic [15:0] fv;
        logic [15:0] fg;
        logic [15:0] fl;
        fv = diff ? (v ^ 16'h8000) : v;
        fg = diff ? (gt ^ 16'h8000) : gt;
        fl = diff ? (lt ^ 16'h8000) : lt;
        if (fg < fl) begin
            win_hit = (fv > fg) && (fv < fl);
        end else begin
            win_hit = (fv < fl) || (fv > fg);
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    sawd_state_t s;
    sawd_state_t next_s;
    logic        prep;
    logic        commit;
    logic        wr;
    logic [4:0]  div;
    logic        tick;
    logic        ext_rise;
    logic        trig;
    logic        sw_start;
    logic        finish;
    logic [15:0] word;
    logic        hit;

    assign div = s.cfg[`SAWD_CFG_DIV_MSB:`SAWD_CFG_DIV_LSB];

    always_comb begin
        next_s = s;
        // Pin passes two flops before the edge detector sees it
        next_s.pin_s1   = ext_convert_start;
        next_s.pin_s2   = s.pin_s1;
        next_s.pin_prev = s.pin_s2;
        ext_rise        = s.pin_s2 & ~s.pin_prev;

        // ********************************************************
        // Bus slave: one wait state, data prepared before pready
        // ********************************************************
        prep   = apb_req.psel & apb_req.penable & ~s.rsp.pready;
        commit = apb_req.psel & apb_req.penable & s.rsp.pready;
        wr     = commit & apb_req.pwrite & apb_req.pstrb[0] & mapped(apb_req.paddr);
        next_s.rsp.pready  = prep;
        next_s.rsp.pslverr = prep & ~mapped(apb_req.paddr);
        next_s.rsp.prdata  = 32'h0000_0000;
        if (prep && !apb_req.pwrite) begin
            if (at_reg(apb_req.paddr, `SAWD_IDX_NEG)) begin
                next_s.rsp.prdata = {27'h0, s.neg_input_code};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_CFG)) begin
                next_s.rsp.prdata = {24'h0, s.cfg[7:2], 2'b00};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_RESL)) begin
                next_s.rsp.prdata = {24'h0, s.res_low};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_RESH)) begin
                next_s.rsp.prdata = {24'h0, s.res_high};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_LTL)) begin
                next_s.rsp.prdata = {24'h0, s.lt_low};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_LTH)) begin
                next_s.rsp.prdata = {24'h0, s.lt_high};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_GTL)) begin
                next_s.rsp.prdata = {24'h0, s.gt_low};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_GTH)) begin
                next_s.rsp.prdata = {24'h0, s.gt_high};
            end else if (at_reg(apb_req.paddr, `SAWD_IDX_CTL)) begin
                next_s.rsp.prdata = {24'h0, s.converter_enable, s.track_mode_select,
                                     s.conv_done_flag, s.conv_busy, s.window_match_flag,
                                     s.start_source_select};
            end
        end

        sw_start = 1'b0;
        if (wr) begin
            if (at_reg(apb_req.paddr, `SAWD_IDX_NEG)) begin
                next_s.neg_input_code = apb_req.pwdata[4:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_CFG)) begin
                next_s.cfg = {apb_req.pwdata[7:2], 2'b00};
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_RESL)) begin
                next_s.res_low = apb_req.pwdata[7:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_RESH)) begin
                next_s.res_high = apb_req.pwdata[7:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_LTL)) begin
                next_s.lt_low = apb_req.pwdata[7:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_LTH)) begin
                next_s.lt_high = apb_req.pwdata[7:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_GTL)) begin
                next_s.gt_low = apb_req.pwdata[7:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_GTH)) begin
                next_s.gt_high = apb_req.pwdata[7:0];
            end
            if (at_reg(apb_req.paddr, `SAWD_IDX_CTL)) begin
                next_s.converter_enable    = apb_req.pwdata[`SAWD_CTL_EN];
                next_s.track_mode_select   = apb_req.pwdata[`SAWD_CTL_TM];
                next_s.conv_done_flag      = apb_req.pwdata[`SAWD_CTL_DONE];
                next_s.window_match_flag   = apb_req.pwdata[`SAWD_CTL_WIN];
                next_s.start_source_select = apb_req.pwdata[`SAWD_CTL_SRC_MSB:0];
                sw_start = apb_req.pwdata[`SAWD_CTL_BUSY]
                         & (s.start_source_select == `SAWD_SRC_SW);
            end
        end

        // ********************************************************
        // Conversion clock divider
        // ********************************************************
        tick = (s.div_cnt >= div);
        next_s.div_cnt = tick ? 5'h00 : s.div_cnt + 5'h01;

        // ********************************************************
        // Trigger selection
        // ********************************************************
        case (s.start_source_select)
            `SAWD_SRC_SW:  trig = sw_start;
            `SAWD_SRC_T0:  trig = timers.t0_ovf;
            `SAWD_SRC_T2:  trig = timers.t2_split ? timers.t2_low_ovf
                                                  : timers.t2_high_ovf;
            `SAWD_SRC_T1:  trig = timers.t1_ovf;
            `SAWD_SRC_EXT: trig = ext_rise;
            `SAWD_SRC_T3:  trig = timers.t3_split ? timers.t3_low_ovf
                                                  : timers.t3_high_ovf;
            default:       trig = 1'b0;
        endcase

        // ********************************************************
        // Track and convert sequencer
        // ********************************************************
        finish = 1'b0;
        case (s.phase)
            SAWD_IDLE: begin
                if (s.converter_enable && trig) begin
                    next_s.conv_busy = 1'b1;
                    next_s.clk_cnt   = 4'h0;
                    // Pin source has already tracked while low
                    if (s.track_mode_select
                        && s.start_source_select != `SAWD_SRC_EXT) begin
                        next_s.phase = SAWD_TRACK;
                    end else begin
                        next_s.phase = SAWD_CONV;
                    end
                end
            end
            SAWD_TRACK: begin
                if (tick) begin
                    next_s.clk_cnt = s.clk_cnt + 4'h1;
                    if (s.clk_cnt == `SAWD_TRACK_CLKS - 4'h1) begin
                        next_s.phase   = SAWD_CONV;
                        next_s.clk_cnt = 4'h0;
                    end
                end
            end
            SAWD_CONV: begin
                if (tick) begin
                    next_s.clk_cnt = s.clk_cnt + 4'h1;
                    if (s.clk_cnt == `SAWD_CONV_CLKS - 4'h1) begin
                        finish = 1'b1;
                    end
                end
            end
            default: begin
                next_s.phase = SAWD_IDLE;
            end
        endcase

        word = fmt(sar_result, s.cfg[`SAWD_CFG_LJ]);
        hit  = win_hit(word, {s.gt_high, s.gt_low}, {s.lt_high, s.lt_low},
                       s.ana.differential);
        if (finish) begin
            next_s.phase          = SAWD_IDLE;
            next_s.conv_busy      = 1'b0;
            next_s.conv_done_flag = 1'b1;
            next_s.res_high       = word[15:8];
            next_s.res_low        = word[7:0];
            if (hit) begin
                next_s.window_match_flag = 1'b1;
            end
        end

        // Disabling aborts any conversion in flight
        if (!s.converter_enable) begin
            next_s.phase     = SAWD_IDLE;
            next_s.conv_busy = 1'b0;
        end

        // ********************************************************
        // Converter array controls
        // ********************************************************
        next_s.ana.power_on       = next_s.converter_enable;
        next_s.ana.convert        = next_s.phase == SAWD_CONV;
        next_s.ana.sar_tick       = tick;
        next_s.ana.neg_input_code = next_s.neg_input_code;
        next_s.ana.differential   = next_s.neg_input_code != `SAWD_NEG_GND;
        if (next_s.track_mode_select) begin
            next_s.ana.track = next_s.converter_enable
                & ((next_s.phase == SAWD_TRACK)
                   | (next_s.phase == SAWD_IDLE & ~next_s.pin_s2
                      & next_s.start_source_select == `SAWD_SRC_EXT));
        end else begin
            next_s.ana.track = next_s.converter_enable & (next_s.phase != SAWD_CONV);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s                   <= '0;
            s.phase             <= SAWD_IDLE;
            s.neg_input_code    <= `SAWD_NEG_RST;
            s.ana.neg_input_code <= `SAWD_NEG_RST;
            s.cfg               <= `SAWD_CFG_RST;
            s.res_low           <= `SAWD_BYTE_RST;
            s.res_high          <= `SAWD_BYTE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp = s.rsp;
    assign ana     = s.ana;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [5:0] gap;
    logic       armed;
    logic [9:0] conv_cyc;

    // Distance between ticks, valid only while the divider is unchanged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap      <= 6'h00;
            armed    <= 1'b0;
            conv_cyc <= 10'h000;
        end else begin
            gap      <= s.ana.sar_tick ? 6'h01 : gap + 6'h01;
            armed    <= (s.cfg == next_s.cfg) & (armed | s.ana.sar_tick);
            conv_cyc <= (s.phase == SAWD_CONV) ? conv_cyc + 10'h001 : 10'h000;
        end
    end

    sequence seq_lp_start;
        s.phase == SAWD_IDLE && s.converter_enable && s.track_mode_select
            && trig && s.start_source_select != `SAWD_SRC_EXT;
    endsequence

    sequence seq_tracking;
        s.phase == SAWD_TRACK && s.conv_busy;
    endsequence

    AST_TRACK_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        seq_lp_start |=> seq_tracking ##1 (s.phase == SAWD_TRACK) [*2])
        else $error("low-power trigger did not start tracking");

    AST_SINGLE_ENDED: assert property (@(posedge pclk) disable iff (!presetn)
        wr && at_reg(apb_req.paddr, `SAWD_IDX_NEG) |=>
            ana.differential == ($past(apb_req.pwdata[4:0]) != 5'h1f))
        else $error("single-ended mode does not follow ground selection");

    AST_NEG_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        prep && !apb_req.pwrite && at_reg(apb_req.paddr, `SAWD_IDX_NEG)
            |=> apb_rsp.pready && apb_rsp.prdata[7:5] == 3'b000)
        else $error("negative select upper bits not zero");

    AST_DIV_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
        s.ana.sar_tick && armed && $past(armed) |-> gap == {1'b0, div} + 6'h01)
        else $error("conversion clock period wrong");

    AST_RIGHT_JUST: assert property (@(posedge pclk) disable iff (!presetn)
        finish && !s.cfg[`SAWD_CFG_LJ] |=>
            s.res_high[7:2] == {6{s.res_high[1]}} && s.res_low == $past(sar_result[7:0]))
        else $error("right-justified result wrong");

    AST_LEFT_JUST: assert property (@(posedge pclk) disable iff (!presetn)
        finish && s.cfg[`SAWD_CFG_LJ] |=>
            s.res_low[5:0] == 6'h00 && s.res_high == $past(sar_result[9:2]))
        else $error("left-justified result wrong");

    AST_DISABLED_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !s.converter_enable |=> !s.conv_busy && !ana.convert)
        else $error("busy while disabled");

    AST_DONE_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        s.conv_busy && finish |=> $fell(s.conv_busy) && s.conv_done_flag)
        else $error("done flag not set at conversion end");

    AST_SW_START: assert property (@(posedge pclk) disable iff (!presetn)
        wr && at_reg(apb_req.paddr, `SAWD_IDX_CTL) && apb_req.pwdata[4]
            && s.start_source_select == 3'h0 && s.converter_enable
            && s.phase == SAWD_IDLE |=> s.conv_busy ##1 s.conv_busy)
        else $error("software start ignored");

    AST_CONV_MIN: assert property (@(posedge pclk) disable iff (!presetn)
        finish && armed |-> conv_cyc >= 10'd9 * ({5'h00, div} + 10'd1))
        else $error("conversion shorter than ten conversion clocks");

    AST_WINDOW_SET: assert property (@(posedge pclk) disable iff (!presetn)
        finish && hit |=> s.window_match_flag [*2])
        else $error("window flag not set on match");

endmodule // sawd_top

// [sawd_params.svh]
// Register indices, field positions, reset values and timing counts
`ifndef SAWD_PARAMS_SVH
`define SAWD_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SAWD_IDX_NEG     8'hba
`define SAWD_IDX_CFG     8'hbc
`define SAWD_IDX_RESL    8'hbd
`define SAWD_IDX_RESH    8'hbe
`define SAWD_IDX_LTL     8'hc5
`define SAWD_IDX_LTH     8'hc6
`define SAWD_IDX_GTL     8'hc7
`define SAWD_IDX_GTH     8'hc8
`define SAWD_IDX_CTL     8'hf8

// ****************************************************************
// Field positions
// ****************************************************************
`define SAWD_CFG_DIV_MSB 7
`define SAWD_CFG_DIV_LSB 3
`define SAWD_CFG_LJ      2
`define SAWD_CTL_EN      7
`define SAWD_CTL_TM      6
`define SAWD_CTL_DONE    5
`define SAWD_CTL_BUSY    4
`define SAWD_CTL_WIN     3
`define SAWD_CTL_SRC_MSB 2

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define SAWD_NEG_RST     5'h00
`define SAWD_CFG_RST     8'hf8
`define SAWD_BYTE_RST    8'h00
`define SAWD_NEG_GND     5'h1f
`define SAWD_SRC_SW      3'h0
`define SAWD_SRC_T0      3'h1
`define SAWD_SRC_T2      3'h2
`define SAWD_SRC_T1      3'h3
`define SAWD_SRC_EXT     3'h4
`define SAWD_SRC_T3      3'h5

// ****************************************************************
// Timing counts in conversion clocks
// ****************************************************************
`define SAWD_TRACK_CLKS  4'h3
`define SAWD_CONV_CLKS   4'ha

`endif

// [sawd_pkg.sv]
// Types shared by the converter control block
package sawd_pkg;

    typedef enum logic [1:0] {SAWD_IDLE, SAWD_TRACK, SAWD_CONV} sawd_phase_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } sawd_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sawd_apb_rsp_t;

    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_low_ovf;
        logic t2_high_ovf;
        logic t2_split;
        logic t3_low_ovf;
        logic t3_high_ovf;
        logic t3_split;
    } sawd_timer_t;

    typedef struct packed {
        logic       power_on;
        logic       track;
        logic       convert;
        logic       sar_tick;
        logic       differential;
        logic [4:0] neg_input_code;
    } sawd_ana_t;

    typedef struct packed {
        sawd_apb_rsp_t rsp;
        sawd_ana_t     ana;
        logic [4:0]    neg_input_code;
        logic [7:0]    cfg;
        logic [7:0]    res_low;
        logic [7:0]    res_high;
        logic [7:0]    lt_low;
        logic [7:0]    lt_high;
        logic [7:0]    gt_low;
        logic [7:0]    gt_high;
        logic          converter_enable;
        logic          track_mode_select;
        logic          conv_done_flag;
        logic          conv_busy;
        logic          window_match_flag;
        logic [2:0]    start_source_select;
        sawd_phase_t   phase;
        logic [4:0]    div_cnt;
        logic [3:0]    clk_cnt;
        logic          pin_s1;
        logic          pin_s2;
        logic          pin_prev;
    } sawd_state_t;

endpackage

// [sawd_sar_model.sv]
// Behavioural converter array returning a code chosen by the bench
`timescale 1ns/1ns
module sawd_sar_model import sawd_pkg::*; (
    // Control from the block
    input  wire sawd_ana_t  ana,
    // Result to the block
    input  wire logic [9:0] value,
    output logic      [9:0] sar_result
);
    // Powered-down array shows inverted junk, so stale codes cannot pass
    assign sar_result = ana.power_on ? value : ~value;
endmodule // sawd_sar_model

// [tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "sawd_params.svh"
module tb_top import sawd_pkg::*; ;
    logic          pclk;
    logic          presetn;
    logic          ext_convert_start;
    logic [9:0]    sar_result;
    logic [9:0]    value;
    logic [7:0]    rdat;
    logic          rerr;
    sawd_apb_req_t req;
    sawd_apb_rsp_t rsp;
    sawd_timer_t   tmr;
    sawd_ana_t     ana;
    int            bad_count;
    int            samples_checked;

    sawd_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .timers(tmr),
        .ext_convert_start(ext_convert_start), .sar_result(sar_result), .ana(ana));
    sawd_sar_model sar (.ana(ana), .value(value), .sar_result(sar_result));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Idle cycle after each transfer keeps one assignment per time step
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}, 4'hf};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            bad_count++;
            test_done;
        end
        rdat = rsp.prdata[7:0];
        rerr = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk({8'h00, rdat}, {8'h00, e});
    endtask

    task automatic run(input logic [7:0] cfg, input logic [7:0] neg, input logic [15:0] lt,
                       input logic [15:0] gt, input logic [7:0] ctl);
        apb(1'b1, `SAWD_IDX_CFG, cfg);
        apb(1'b1, `SAWD_IDX_NEG, neg);
        apb(1'b1, `SAWD_IDX_LTL, lt[7:0]);
        apb(1'b1, `SAWD_IDX_LTH, lt[15:8]);
        apb(1'b1, `SAWD_IDX_GTL, gt[7:0]);
        apb(1'b1, `SAWD_IDX_GTH, gt[15:8]);
        apb(1'b1, `SAWD_IDX_CTL, ctl);
    endtask

    task automatic wconv(input int lo, input logic tm);
        int n;
        int t;
        n = 0;
        t = 0;
        while (ana.convert !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
            if (ana.track === 1'b1) t++;
        end
        if (ana.convert !== 1'b1) begin
            bad_count++;
            test_done;
        end
        if (tm) chk(16'(t > 2 && t < 5), 16'h1);
        n = 0;
        while (ana.convert === 1'b1 && n < 1000) begin
            chk({15'h0, ana.track}, 16'h0);
            @(posedge pclk);
            n++;
        end
        if (ana.convert === 1'b1) begin
            bad_count++;
            test_done;
        end
        chk(16'(n >= lo), 16'h1);
    endtask

    task automatic t_regs;
        int c;
        c = 0;
        rd(`SAWD_IDX_CFG, 8'hf8);
        rd(`SAWD_IDX_NEG, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        chk({15'h0, rerr}, 16'h1);
        chk({8'h00, rdat}, 16'h0);
        apb(1'b1, `SAWD_IDX_NEG, 8'hff);
        rd(`SAWD_IDX_NEG, 8'h1f);
        chk({15'h0, ana.differential}, 16'h0);
        chk({11'h0, ana.neg_input_code}, 16'h001f);
        // Reset divider of 31 gives one tick every 32 cycles
        repeat (64) begin
            @(posedge pclk);
            c += ana.sar_tick;
        end
        chk(16'(c), 16'h2);
        $display("test regs done");
    endtask

    task automatic t_sw_inside;
        value = 10'h060;
        run(8'h00, 8'h1f, 16'h0080, 16'h0040, 8'h80);
        repeat (2) @(posedge pclk);
        chk({15'h0, ana.track}, 16'h1);
        apb(1'b1, `SAWD_IDX_CTL, 8'h90);
        wconv(10, 1'b0);
        rd(`SAWD_IDX_RESH, 8'h00);
        rd(`SAWD_IDX_RESL, 8'h60);
        rd(`SAWD_IDX_CTL, 8'ha8);
        $display("test sw inside done");
    endtask

    task automatic t_left_outside;
        value = 10'h3c5;
        run(8'h0c, 8'h1f, 16'h1000, 16'h2000, 8'h80);
        apb(1'b1, `SAWD_IDX_CTL, 8'h90);
        wconv(19, 1'b0);
        rd(`SAWD_IDX_RESH, 8'hf1);
        rd(`SAWD_IDX_RESL, 8'h40);
        rd(`SAWD_IDX_CTL, 8'ha8);
        $display("test left outside done");
    endtask

    task automatic t_timer_diff;
        value = 10'h001;
        run(8'h00, 8'h00, 16'h0040, 16'hffff, 8'hc1);
        chk({15'h0, ana.differential}, 16'h1);
        tmr.t0_ovf <= 1'b1;
        @(posedge pclk);
        tmr.t0_ovf <= 1'b0;
        wconv(10, 1'b1);
        rd(`SAWD_IDX_RESL, 8'h01);
        rd(`SAWD_IDX_CTL, 8'he9);
        $display("test timer diff done");
    endtask

    task automatic t_ext_pin;
        value = 10'h2aa;
        run(8'h00, 8'h1f, 16'h0000, 16'h0000, 8'hc4);
        chk({15'h0, ana.track}, 16'h1);
        ext_convert_start <= 1'b1;
        wconv(10, 1'b0);
        rd(`SAWD_IDX_RESH, 8'hfe);
        rd(`SAWD_IDX_RESL, 8'haa);
        ext_convert_start <= 1'b0;
        // Split timer: high overflow must be ignored, low one starts
        tmr.t2_split <= 1'b1;
        apb(1'b1, `SAWD_IDX_CTL, 8'h82);
        tmr.t2_high_ovf <= 1'b1;
        @(posedge pclk);
        tmr.t2_high_ovf <= 1'b0;
        @(posedge pclk);
        chk({15'h0, ana.convert}, 16'h0);
        tmr.t2_low_ovf <= 1'b1;
        @(posedge pclk);
        tmr.t2_low_ovf <= 1'b0;
        wconv(10, 1'b0);
        $display("test ext pin done");
    endtask

    task automatic t_refused;
        int c;
        logic [7:0] w [3] = '{8'h91, 8'h10, 8'h10};
        c = 0;
        run(8'h00, 8'h1f, 16'h0000, 16'h0000, 8'h81);
        foreach (w[k]) begin
            apb(1'b1, `SAWD_IDX_CTL, w[k]);
            repeat (20) begin
                @(posedge pclk);
                if (ana.convert !== 1'b0) c++;
            end
        end
        chk(16'(c), 16'h0);
        rd(`SAWD_IDX_CTL, 8'h00);
        chk({15'h0, ana.power_on}, 16'h0);
        $display("test refused done");
    endtask

    initial begin
        presetn = 1'b0;
        req = '0;
        tmr = '0;
        ext_convert_start = 1'b0;
        value = 10'h000;
        bad_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_sw_inside;
        t_left_outside;
        t_timer_diff;
        t_ext_pin;
        t_refused;
        test_done;
    end
endmodule // tb_top
